// >>> hw/gswic_glitch.sv
`default_nettype none
module gswic_glitch #(
    parameter int unsigned W = 1,
    parameter int unsigned LEN = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    localparam int unsigned CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(LEN - 1);

    logic [W-1:0] q_r;

    // A new level is taken only after LEN stable cycles; pulses shorter than that vanish
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        logic [CW-1:0] cnt_r;
        always_ff @(posedge clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                cnt_r <= '0;
                q_r[i] <= 1'b0;
            end
            else if (d[i] == q_r[i])
            begin
                cnt_r <= '0;
            end
            else if (cnt_r == CNT_LAST)
            begin
                cnt_r <= '0;
                q_r[i] <= d[i];
            end
            else
            begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign q = q_r;
endmodule // gswic_glitch
`default_nettype wire

// >>> hw/gswic_sync.sv
`default_nettype none
module gswic_sync #(
    parameter int unsigned W = 1,
    parameter int unsigned STAGES = 2
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] st_r [STAGES];

    // Each stage but the last is read only by the next stage; the last drives q
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < STAGES; i++)
            begin
                st_r[i] <= '0;
            end
        end
        else
        begin
            st_r[0] <= d;
            for (int i = 1; i < STAGES; i++)
            begin
                st_r[i] <= st_r[i-1];
            end
        end
    end

    assign q = st_r[STAGES-1];
endmodule // gswic_sync
`default_nettype wire

// >>> hw/gswic_top.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`default_nettype none
module gswic_top
    import gswic_pkg::*;
#(
    parameter logic [SEL_W-1:0] LINE_A_PIN = 5'h00,
    parameter logic [SEL_W-1:0] LINE_B_PIN = 5'h01,
    parameter int unsigned FILT_LEN = FILT_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PORT_W-1:0] port_a_in,
    input wire logic [PORT_W-1:0] port_b_in,
    input wire logic [PORT_W-1:0] port_c_in,
    output logic [PORT_W-1:0] port_a_out,
    output logic [PORT_W-1:0] port_b_out,
    output logic [PORT_W-1:0] port_c_out,
    output logic pin_wake_req,
    output logic serial1_wake_req,
    output logic serial2_wake_req,
    output logic line_d_wake_req,
    output logic [NLINE-1:0] line_pending,
    output logic irq
);
    function automatic logic pin_pick(input logic [NPIN-1:0] v, input logic [SEL_W-1:0] code);
        logic r;
        r = 1'b0;
        if (code < SEL_LIMIT)
        begin
            r = v[code];
        end
        return r;
    endfunction

    function automatic logic addr_mapped(input logic [31:0] a);
        logic hit;
        hit = (a == ADDR_SEL_C) || (a == ADDR_SEL_D) || (a == ADDR_WFILT) || (a == ADDR_PEND) || (a == ADDR_MASK);
        for (int i = 0; i < NLINE; i++)
        begin
            hit = hit || (a == ADDR_CFG[i]);
        end
        for (int i = 0; i < NPORT; i++)
        begin
            hit = hit || (a == ADDR_IN[i]) || (a == ADDR_OUT[i]) || (a == ADDR_SET[i]) || (a == ADDR_WAKE[i]);
        end
        return hit;
    endfunction

    function automatic logic trig(input logic [MODE_W-1:0] mode, input logic lvl, input logic prev);
        logic t;
        t = 1'b0;
        unique case (mode)
            GSWIC_MODE_OFF: t = 1'b0;
            GSWIC_MODE_RISE: t = lvl && !prev;
            GSWIC_MODE_FALL: t = !lvl && prev;
            GSWIC_MODE_BOTH: t = lvl != prev;
            GSWIC_MODE_HIGH: t = lvl;
            GSWIC_MODE_LOW: t = !lvl;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic aw_hold_r, w_hold_r;
    logic [31:0] aw_addr_r, w_data_r, rdata_r, rd_word;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;
    logic wr_go, wr_lo, wr_hi;
    logic [PORT_W-1:0] out_r [NPORT];
    logic [PORT_W-1:0] wake_en_r [NPORT];
    logic [MODE_W-1:0] mode_r [NLINE];
    logic [NLINE-1:0] filt_en_r, pend_r, mask_r, lvl, lvl_prev_r, ev, clr;
    logic [SEL_W-1:0] sel_c_r, sel_d_r;
    logic [SEL_W-1:0] line_code [NLINE];
    logic [3:0] wfilt_r;
    logic [NPIN-1:0] pin_s, pin_f, wsrc, wsrc_prev_r, wake_all;
    logic ser1_src, ser2_src, lined_src, ser1_prev_r, ser2_prev_r, lined_prev_r;
    logic pin_wake_r, ser1_wake_r, ser2_wake_r, lined_wake_r, irq_r;

    // Address and data are taken in either order; the write waits for both
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awready_r <= 1'b1;
            aw_hold_r <= 1'b0;
            aw_addr_r <= WORD_ZERO;
        end
        else if (s_axi_awvalid && awready_r)
        begin
            awready_r <= 1'b0;
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
        else if (bvalid_r && s_axi_bready)
        begin
            awready_r <= 1'b1;
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wready_r <= 1'b1;
            w_hold_r <= 1'b0;
            w_data_r <= WORD_ZERO;
            w_strb_r <= 4'h0;
        end
        else if (s_axi_wvalid && wready_r)
        begin
            wready_r <= 1'b0;
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
        else if (bvalid_r && s_axi_bready)
        begin
            wready_r <= 1'b1;
            w_hold_r <= 1'b0;
        end
    end

    assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_lo = wr_go && w_strb_r[0];
    assign wr_hi = wr_go && w_strb_r[1];

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= addr_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid_r && s_axi_bready)
        begin
            bvalid_r <= 1'b0;
        end
    end

    always_comb
    begin
        rd_word = WORD_ZERO;
        for (int i = 0; i < NLINE; i++)
        begin
            if (s_axi_araddr == ADDR_CFG[i])
            begin
                rd_word[CFG_FILT_BIT] = filt_en_r[i];
                rd_word[CFG_MODE_MSB:CFG_MODE_LSB] = mode_r[i];
            end
        end
        for (int i = 0; i < NPORT; i++)
        begin
            if (s_axi_araddr == ADDR_IN[i])
            begin
                rd_word[PORT_W-1:0] = pin_s[i*PORT_W +: PORT_W];
            end
            if (s_axi_araddr == ADDR_OUT[i])
            begin
                rd_word[PORT_W-1:0] = out_r[i];
            end
            if (s_axi_araddr == ADDR_WAKE[i])
            begin
                rd_word[PORT_W-1:0] = wake_en_r[i];
            end
        end
        if (s_axi_araddr == ADDR_SEL_C)
        begin
            rd_word[SEL_W-1:0] = sel_c_r;
        end
        if (s_axi_araddr == ADDR_SEL_D)
        begin
            rd_word[SEL_W-1:0] = sel_d_r;
        end
        if (s_axi_araddr == ADDR_WFILT)
        begin
            rd_word[3:0] = wfilt_r;
        end
        if (s_axi_araddr == ADDR_PEND)
        begin
            rd_word[NLINE-1:0] = pend_r;
        end
        if (s_axi_araddr == ADDR_MASK)
        begin
            rd_word[NLINE-1:0] = mask_r;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= WORD_ZERO;
            rresp_r <= RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_r)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
        begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    // Output data: direct writes and set writes share one register per port
    for (genvar p = 0; p < NPORT; p++)
    begin : g_port
        always_ff @(posedge clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                out_r[p] <= PORT_RST;
            end
            else if (wr_lo && aw_addr_r == ADDR_OUT[p])
            begin
                out_r[p] <= w_data_r[PORT_W-1:0];
            end
            else if (wr_lo && aw_addr_r == ADDR_SET[p])
            begin
                // Upper three bytes are dropped, so stray reserved bits are harmless
                out_r[p] <= out_r[p] | w_data_r[PORT_W-1:0];
            end
        end

        always_ff @(posedge clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                wake_en_r[p] <= PORT_RST;
            end
            else if (wr_lo && aw_addr_r == ADDR_WAKE[p])
            begin
                wake_en_r[p] <= w_data_r[PORT_W-1:0];
            end
        end
        assign wake_all[p*PORT_W +: PORT_W] = wake_en_r[p];
    end

    // Selects, wake filter and interrupt mask
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sel_c_r <= SEL_C_RST;
            sel_d_r <= SEL_D_RST;
            wfilt_r <= 4'h0;
            mask_r <= '0;
        end
        else if (wr_lo)
        begin
            if (aw_addr_r == ADDR_SEL_C)
            begin
                sel_c_r <= w_data_r[SEL_W-1:0];
            end
            if (aw_addr_r == ADDR_SEL_D)
            begin
                sel_d_r <= w_data_r[SEL_W-1:0];
            end
            if (aw_addr_r == ADDR_WFILT)
            begin
                wfilt_r <= w_data_r[3:0];
            end
            if (aw_addr_r == ADDR_MASK)
            begin
                mask_r <= w_data_r[NLINE-1:0];
            end
        end
    end

    // Pins are resynchronised first; the filter runs on the synchronised copy
    gswic_sync #(.W(NPIN), .STAGES(SYNC_STAGES)) gswic_sync_inst (
        .clk(clk),
        .reset_n(reset_n),
        .d({port_c_in, port_b_in, port_a_in}),
        .q(pin_s)
    );

    gswic_glitch #(.W(NPIN), .LEN(FILT_LEN)) gswic_glitch_inst (
        .clk(clk),
        .reset_n(reset_n),
        .d(pin_s),
        .q(pin_f)
    );

    assign line_code[0] = LINE_A_PIN;
    assign line_code[1] = LINE_B_PIN;
    assign line_code[LINE_C] = sel_c_r;
    assign line_code[LINE_D] = sel_d_r;

    for (genvar k = 0; k < NLINE; k++)
    begin : g_line
        always_ff @(posedge clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                mode_r[k] <= GSWIC_MODE_OFF;
            end
            else if (wr_lo && aw_addr_r == ADDR_CFG[k])
            begin
                mode_r[k] <= w_data_r[CFG_MODE_MSB:CFG_MODE_LSB];
            end
        end

        always_ff @(posedge clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                filt_en_r[k] <= 1'b0;
            end
            else if (wr_hi && aw_addr_r == ADDR_CFG[k])
            begin
                filt_en_r[k] <= w_data_r[CFG_FILT_BIT];
            end
        end

        // Reserved select codes read as a quiet low input
        assign lvl[k] = filt_en_r[k] ? pin_pick(pin_f, line_code[k]) : pin_pick(pin_s, line_code[k]);
        // A mode field that software leaves at 6 or 7 stays silent
        assign ev[k] = trig(mode_r[k], lvl[k], lvl_prev_r[k]);
        assign clr[k] = wr_lo && aw_addr_r == ADDR_PEND && w_data_r[k];
    end

    // A trigger in the clearing cycle keeps the flag set
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lvl_prev_r <= '0;
            pend_r <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            lvl_prev_r <= lvl;
            pend_r <= ev | (pend_r & ~clr);
            irq_r <= |(pend_r & mask_r);
        end
    end

    // Wakeup sources: each reports a level change, filtered or raw; the pin source only on pins whose wake enable bit is set
    assign wsrc = wfilt_r[WF_PINS_BIT] ? pin_f : pin_s;
    assign ser1_src = wfilt_r[WF_SER1_BIT] ? pin_f[SER1_PIN] : pin_s[SER1_PIN];
    assign ser2_src = wfilt_r[WF_SER2_BIT] ? pin_f[SER2_PIN] : pin_s[SER2_PIN];
    assign lined_src = wfilt_r[WF_LINED_BIT] ? pin_pick(pin_f, sel_d_r) : pin_pick(pin_s, sel_d_r);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wsrc_prev_r <= '0;
            ser1_prev_r <= 1'b0;
            ser2_prev_r <= 1'b0;
            lined_prev_r <= 1'b0;
            pin_wake_r <= 1'b0;
            ser1_wake_r <= 1'b0;
            ser2_wake_r <= 1'b0;
            lined_wake_r <= 1'b0;
        end
        else
        begin
            wsrc_prev_r <= wsrc;
            ser1_prev_r <= ser1_src;
            ser2_prev_r <= ser2_src;
            lined_prev_r <= lined_src;
            pin_wake_r <= |((wsrc ^ wsrc_prev_r) & wake_all);
            ser1_wake_r <= ser1_src ^ ser1_prev_r;
            ser2_wake_r <= ser2_src ^ ser2_prev_r;
            lined_wake_r <= lined_src ^ lined_prev_r;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign port_a_out = out_r[0];
    assign port_b_out = out_r[1];
    assign port_c_out = out_r[2];
    assign pin_wake_req = pin_wake_r;
    assign serial1_wake_req = ser1_wake_r;
    assign serial2_wake_req = ser2_wake_r;
    assign line_d_wake_req = lined_wake_r;
    assign line_pending = pend_r;
    assign irq = irq_r;

    a_set_forces_one: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_lo && aw_addr_r == ADDR_SET[0]) |=> ((out_r[0] & $past(w_data_r[PORT_W-1:0])) == $past(w_data_r[PORT_W-1:0]))
        && ((out_r[0] & ~$past(w_data_r[PORT_W-1:0])) == ($past(out_r[0]) & ~$past(w_data_r[PORT_W-1:0]))))
        else $error("set write did not force ones only");
    a_wake_en_store: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_lo && aw_addr_r == ADDR_WAKE[1]) |=> wake_en_r[1] == $past(w_data_r[PORT_W-1:0]))
        else $error("wake enable not stored");
    a_rise_sets_pend: assert property (@(posedge clk) disable iff (!reset_n)
        (mode_r[LINE_C] == GSWIC_MODE_RISE && lvl[LINE_C] && !lvl_prev_r[LINE_C]) |=> pend_r[LINE_C])
        else $error("rising edge missed");
    a_high_level_pend: assert property (@(posedge clk) disable iff (!reset_n)
        (mode_r[LINE_C] == GSWIC_MODE_HIGH && lvl[LINE_C]) |=> pend_r[LINE_C])
        else $error("high level missed");
    a_off_stays_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (mode_r[0] == GSWIC_MODE_OFF && !pend_r[0]) |=> !pend_r[0])
        else $error("disabled line raised pending");
    a_clear_pend_c: assert property (@(posedge clk) disable iff (!reset_n)
        (clr[LINE_C] && !ev[LINE_C]) |=> !pend_r[LINE_C])
        else $error("line C flag not cleared");
    a_set_beats_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (clr[LINE_C] && ev[LINE_C]) |=> pend_r[LINE_C])
        else $error("event lost under clear");
    a_irq_follows: assert property (@(posedge clk) disable iff (!reset_n)
        (|(pend_r & mask_r)) |=> irq_r)
        else $error("unmasked pending without irq");
    a_sel_c_store: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_lo && aw_addr_r == ADDR_SEL_C) |=> sel_c_r == $past(w_data_r[SEL_W-1:0]))
        else $error("line C select not stored");
    a_bvalid_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (bvalid_r && !s_axi_bready) |=> bvalid_r && $stable(bresp_r))
        else $error("write response dropped");
endmodule // gswic_top
`default_nettype wire

// >>> pkg/gswic_pkg.sv
`default_nettype none
package gswic_pkg;
    localparam int unsigned PORT_W = 8;
    localparam int unsigned NPORT = 3;
    localparam int unsigned NPIN = PORT_W * NPORT;
    localparam int unsigned NLINE = 4;
    localparam int unsigned SEL_W = 5;
    localparam int unsigned MODE_W = 3;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned FILT_CYCLES = 4;

    localparam logic [31:0] ADDR_CFG [NLINE] = '{32'h4000_A860, 32'h4000_A864, 32'h4000_A868, 32'h4000_A86C};
    localparam logic [31:0] ADDR_IN [NPORT] = '{32'h4000_B008, 32'h4000_B408, 32'h4000_B808};
    localparam logic [31:0] ADDR_OUT [NPORT] = '{32'h4000_B00C, 32'h4000_B40C, 32'h4000_B80C};
    localparam logic [31:0] ADDR_SET [NPORT] = '{32'h4000_B010, 32'h4000_B410, 32'h4000_B810};
    localparam logic [31:0] ADDR_WAKE [NPORT] = '{32'h4000_BC08, 32'h4000_BC0C, 32'h4000_BC10};
    localparam logic [31:0] ADDR_SEL_C = 32'h4000_BC14;
    localparam logic [31:0] ADDR_SEL_D = 32'h4000_BC18;
    localparam logic [31:0] ADDR_WFILT = 32'h4000_BC1C;
    localparam logic [31:0] ADDR_PEND = 32'h4000_A814;
    localparam logic [31:0] ADDR_MASK = 32'h4000_A818;

    localparam int unsigned CFG_FILT_BIT = 8;
    localparam int unsigned CFG_MODE_LSB = 5;
    localparam int unsigned CFG_MODE_MSB = 7;
    localparam int unsigned WF_PINS_BIT = 0;
    localparam int unsigned WF_SER1_BIT = 1;
    localparam int unsigned WF_SER2_BIT = 2;
    localparam int unsigned WF_LINED_BIT = 3;
    localparam int unsigned LINE_C = 2;
    localparam int unsigned LINE_D = 3;
    localparam int unsigned SER1_PIN = 10;
    localparam int unsigned SER2_PIN = 2;

    localparam logic [SEL_W-1:0] SEL_C_RST = 5'h0F;
    localparam logic [SEL_W-1:0] SEL_D_RST = 5'h10;
    localparam logic [SEL_W-1:0] SEL_LIMIT = 5'h18;
    localparam logic [PORT_W-1:0] PORT_RST = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [MODE_W-1:0] {
        GSWIC_MODE_OFF = 3'h0,
        GSWIC_MODE_RISE = 3'h1,
        GSWIC_MODE_FALL = 3'h2,
        GSWIC_MODE_BOTH = 3'h3,
        GSWIC_MODE_HIGH = 3'h4,
        GSWIC_MODE_LOW = 3'h5
    } gswic_mode_e;
endpackage
`default_nettype wire

// >>> test/gswic_pins.sv
`default_nettype none
module gswic_pins (
    input wire logic clk,
    input wire logic [23:0] want,
    output var logic [7:0] pa,
    output var logic [7:0] pb,
    output var logic [7:0] pc
);
    timeunit 1ns;
    timeprecision 1ps;
    // Levels change only after an edge, so the synchroniser sees clean steps
    initial {pc, pb, pa} = 24'h000000;
    always @(posedge clk)
        {pc, pb, pa} <= want;
endmodule // gswic_pins
`default_nettype wire

// >>> test/gswic_top_bench.sv
`default_nettype none
module gswic_top_bench;
    import gswic_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rd, s = 32'h63E7BA93;
    logic awr, wrd, bv, arr, rv, irq, idle;
    logic [1:0] br, rr;
    logic [7:0] pa, pb, pc, oa, ob, oc;
    logic [3:0] pend;
    wire [3:0] wake;
    int wk[4];
    logic [4:0] c;
    logic [23:0] want = '0;
    logic [33:0] q[$];
    int err_count = 0, total_checks = 0;
    gswic_top #(.FILT_LEN(2)) gswic_top_inst (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rready), .port_a_in(pa), .port_b_in(pb), .port_c_in(pc), .port_a_out(oa), .port_b_out(ob),
        .port_c_out(oc), .pin_wake_req(wake[0]), .serial1_wake_req(wake[1]), .serial2_wake_req(wake[2]),
        .line_d_wake_req(wake[3]), .line_pending(pend), .irq(irq));
    gswic_pins gswic_pins_inst (.clk(clk), .want(want), .pa(pa), .pb(pb), .pc(pc));
    initial forever #12.5 clk = ~clk;
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // A hung handshake counts as a mismatch and ends the run
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 200)
        begin
            err_count++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] eb);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1;
        wv <= 1;
        bready <= 1;
        do
        begin
            tick(n);
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
        end while (!bv);
        bready <= 0;
        chk("bresp", {32'h0, br}, {32'h0, eb});
    endtask
    // Expected word goes to the queue; the monitor compares when the answer arrives
    task automatic rd_chk(input logic [31:0] a, input logic [33:0] e);
        int n;
        n = 0;
        @(posedge clk);
        q.push_back(e);
        araddr <= a;
        arv <= 1;
        rready <= 1;
        do
        begin
            tick(n);
            if (arr) arv <= 0;
        end while (!rv);
        rready <= 0;
    endtask
    always @(posedge clk)
        if (rv && rready && q.size() > 0)
            chk("rdata", {rr, rd}, q.pop_front());
    always @(posedge clk)
        for (int i = 0; i < 4; i++)
            if (wake[i])
                wk[i]++;
    // Pins go high for n cycles; wake pulses are counted per output, three bits each
    task automatic wake_step(input logic [23:0] p, input int n, input logic [11:0] e);
        @(posedge clk);
        wk = '{0, 0, 0, 0};
        want <= p;
        repeat (n) @(posedge clk);
        want <= '0;
        repeat (14) @(posedge clk);
        chk("wake", {22'h0, 3'(wk[3]), 3'(wk[2]), 3'(wk[1]), 3'(wk[0])}, {22'h0, e});
    endtask
    task automatic pend_is(input logic e);
        @(negedge clk);
        chk("pending", {33'h0, pend[LINE_C]}, {33'h0, e});
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1;
        rd_chk(ADDR_SEL_C, {RESP_OKAY, 32'h0000000F});
        rd_chk(ADDR_SEL_D, {RESP_OKAY, 32'h00000010});
        rd_chk(ADDR_WFILT, {RESP_OKAY, WORD_ZERO});
        for (int i = 0; i < 4; i++)
            rd_chk(ADDR_CFG[i], {RESP_OKAY, WORD_ZERO});
        for (int i = 0; i < 3; i++)
        begin
            rd_chk(ADDR_WAKE[i], {RESP_OKAY, WORD_ZERO});
            s = nx(s);
            wr(ADDR_WAKE[i], {24'h0, s[7:0]}, RESP_OKAY);
            rd_chk(ADDR_WAKE[i], {RESP_OKAY, 24'h0, s[7:0]});
            wr(ADDR_SET[i], 32'h000000A5, RESP_OKAY);
            wr(ADDR_SET[i], 32'h00000030, RESP_OKAY);
            rd_chk(ADDR_OUT[i], {RESP_OKAY, 32'h000000B5});
            rd_chk(ADDR_SET[i], {RESP_OKAY, WORD_ZERO});
        end
        chk("outs", {10'h0, oa, ob, oc}, {10'h0, 24'hB5B5B5});
        wr(ADDR_WAKE[0], 32'h00000004, RESP_OKAY);
        wake_step(24'h010404, 1, 12'h492);
        wake_step(24'h000020, 1, 12'h000);
        wr(ADDR_WFILT, 32'h00000009, RESP_OKAY);
        wake_step(24'h010404, 1, 12'h090);
        wr(ADDR_WFILT, 32'h0000000F, RESP_OKAY);
        rd_chk(ADDR_WFILT, {RESP_OKAY, 32'h0000000F});
        wake_step(24'h010404, 1, 12'h000);
        wake_step(24'h010404, 4, 12'h492);
        wr(32'h4000A000, 32'h1, RESP_SLVERR);
        rd_chk(32'h4000A000, {RESP_SLVERR, WORD_ZERO});
        wr(ADDR_MASK, 32'h4, RESP_OKAY);
        // Codes 6 and 7 are never written; odd modes also run the input filter
        for (int m = 0; m < 6; m++)
        begin
            s = nx(s);
            c = 5'(s % 24);
            idle = (m == 2 || m == 5);
            want <= {23'h0, idle} << c;
            wr(ADDR_SEL_C, {27'h0, c}, RESP_OKAY);
            wr(ADDR_CFG[LINE_C], {23'h0, m[0], m[2:0], 5'h0}, RESP_OKAY);
            repeat (12) @(posedge clk);
            wr(ADDR_PEND, 32'h4, RESP_OKAY);
            pend_is(1'b0);
            @(posedge clk);
            want <= {23'h0, !idle} << c;
            for (int k = 0; k < 20 && pend[LINE_C] !== 1'b1; k++)
                @(posedge clk);
            pend_is(m != 0);
            @(negedge clk);
            chk("irq", {33'h0, irq}, {33'h0, m != 0});
            if (m == 4)
            begin
                // Level still high, so the clear meets a trigger in the same cycle
                wr(ADDR_PEND, 32'h4, RESP_OKAY);
                pend_is(1'b1);
                wr(ADDR_MASK, 32'h0, RESP_OKAY);
                @(negedge clk);
                chk("masked", {33'h0, irq}, 34'h0);
                wr(ADDR_MASK, 32'h4, RESP_OKAY);
            end
            @(posedge clk);
            want <= {23'h0, idle} << c;
            repeat (12) @(posedge clk);
            wr(ADDR_PEND, 32'h4, RESP_OKAY);
            pend_is(1'b0);
        end
        stop_test();
    end
endmodule // gswic_top_bench
`default_nettype wire
